// ---- design/bzcs_sampler.v ----
// Purpose: digital sampling and event timing behind the rotor-position comparator
// Assumes: PHASE_DRIVE_ON comes from PWM logic on SYS_CLK; COMP_OUT is asynchronous
// Notes:   timer clock is SYS_CLK; motor timer is a free-running counter here
//
// How it works
// - ignore comparator during start-up filter after enable
// - tacho capture on fourth cycle after toggle
// - off-time mode: zero-cross capture 3 cycles later
// - off-time mode: sensor bit one cycle later
// - continuous mode: zero-cross one period plus three
// - demag capture one period plus three cycles
// - on-time delay: sensor bit delay plus one
// - on-time delay: zero-cross delay plus three
// - on-time delay at rate: plus period plus three
// - input select: flag next cycle, settle, resample
// - rate field divides timer clock by 4..32
//
// The placing of the registers and strobed register access are this design's own decisions.
`include "bzcs_defines.vh"

module bzcs_sampler #(
  parameter DW = `BZCS_DATA_W,  // register data width
  parameter AW = `BZCS_ADDR_W   // register index width
) (
  input  wire          SYS_CLK,         // timer clock, 200 MHz
  input  wire          RESET,           // synchronous reset, high
  input  wire [AW-1:0] REG_ADDR,        // register index
  input  wire [DW-1:0] REG_WDATA,       // write data
  input  wire          REG_WR,          // write strobe
  input  wire          REG_RD,          // read strobe
  output reg  [DW-1:0] REG_RDATA,       // read data, cycle after strobe
  input  wire          COMP_OUT,        // comparator output, asynchronous
  input  wire          PHASE_DRIVE_ON,  // phase_drive_output is on
  output reg  [1:0]    INPUT_SELECT,    // phase_sense_input mux select
  output reg           COMP_POWER,      // comparator powered
  output reg           SENSOR_STATE,    // sensor_state_bit
  output reg           ZC_EVENT,        // zero-crossing pulse
  output reg           DEMAG_EVENT,     // demagnetisation pulse
  output reg           TACHO_EVENT      // tachogenerator capture pulse
);

  localparam integer STARTUP_INT = `BZCS_STARTUP_CYC;
  localparam integer SETTLE_INT  = `BZCS_SETTLE_CYC;
  localparam integer DIV_INT     = `BZCS_SCF_BASE_DIV;
  // counters sized to the counts they hold; upper bits cut on purpose
  localparam [9:0]   STARTUP_CYC = STARTUP_INT[9:0];
  localparam [4:0]   SETTLE_CYC  = SETTLE_INT[4:0];
  localparam [5:0]   BASE_DIV    = DIV_INT[5:0];

  function [5:0] scf_period;
    input [1:0] rate;
    begin
      scf_period = BASE_DIV << rate;
    end
  endfunction

  function [3:0] sel_onehot;
    input [1:0] sel;
    begin
      sel_onehot = 4'h1 << sel;
    end
  endfunction

  // register index match, shared by write decode and read mux
  function reg_hit;
    input [AW-1:0] addr;
    input [AW-1:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  reg  [DW-1:0] cfg_reg;
  reg  [3:0]    sel_flag_reg;
  reg           ready_reg;
  reg  [15:0]   timer_reg;
  reg  [15:0]   zc_cap_reg;
  reg  [15:0]   dm_cap_reg;
  reg  [15:0]   tc_cap_reg;
  reg  [9:0]    start_cnt_reg;
  reg           comp_prev_on_reg;
  reg  [5:0]    div_cnt_reg;
  reg           drive_prev_reg;
  reg  [7:0]    dly_cnt_reg;
  reg           scf_arm_reg;
  reg  [4:0]    settle_cnt_reg;
  reg           cmp_prev_reg;
  reg           dm_last_reg;
  reg  [1:0]    zc_pipe_reg;
  reg  [1:0]    dm_pipe_reg;
  reg  [2:0]    tc_pipe_reg;
  reg  [DW-1:0] rd_next;

  wire          cmp_lvl;
  wire [1:0]    mode      = cfg_reg[`BZCS_CFG_MODE_HI:`BZCS_CFG_MODE_LO];
  wire [1:0]    rate      = cfg_reg[`BZCS_CFG_RATE_HI:`BZCS_CFG_RATE_LO];
  wire [7:0]    ds        = cfg_reg[`BZCS_CFG_DLY_HI:`BZCS_CFG_DLY_LO];
  wire          comp_on   = cfg_reg[`BZCS_CFG_CKE] | cfg_reg[`BZCS_CFG_REF];
  wire          ds_zero   = (ds == 8'h00);
  wire          drive_rise = PHASE_DRIVE_ON & ~drive_prev_reg;
  wire          cmp_toggle = cmp_lvl ^ cmp_prev_reg;
  wire          wr_phase  = REG_WR & reg_hit(REG_ADDR, `BZCS_OFS_PHASE);
  wire          wr_cfg    = REG_WR & reg_hit(REG_ADDR, `BZCS_OFS_CONFIG);
  reg           mode_smp;

  // comparator passes the synchroniser before anything reads it
  bzcs_sync u_sync (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .async_in  (COMP_OUT),
    .level_reg (cmp_lvl)
  );

  // comparator output trusted only after the start-up filter
  wire active = comp_on & comp_prev_on_reg & (start_cnt_reg == 10'h000);

  // sampling clock tick
  wire tick = (div_cnt_reg == scf_period(rate) - 6'h01);

  // sample point chosen by mode
  always @*
  begin
    mode_smp = 1'b0;
    case (mode)
      `BZCS_MODE_OFF_END:    mode_smp = drive_rise;
      `BZCS_MODE_CONT:       mode_smp = tick;
      `BZCS_MODE_ON_DLY:     mode_smp = ds_zero ? drive_rise : (dly_cnt_reg == 8'h01);
      `BZCS_MODE_ON_DLY_SCF: mode_smp = tick & scf_arm_reg & PHASE_DRIVE_ON;
      default:               mode_smp = 1'b0;
    endcase
  end

  // sample after an input change: settled, on a tick, until the first one sets ready
  wire sel_smp  = active & tick & ~ready_reg & (settle_cnt_reg == 5'h00);
  wire smp      = active & mode_smp;
  wire smp_any  = smp | sel_smp;
  wire zc_trig  = smp & (cmp_lvl != SENSOR_STATE);
  wire dm_trig  = active & tick & cfg_reg[`BZCS_CFG_DEMAG] & (cmp_lvl != dm_last_reg);
  wire tc_trig  = active & cfg_reg[`BZCS_CFG_TACHO] & cmp_toggle;

  // start-up filter
  always @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      comp_prev_on_reg <= 1'b0;
      COMP_POWER       <= 1'b0;
      start_cnt_reg    <= 10'h000;
    end
    else
    begin
      comp_prev_on_reg <= comp_on;
      COMP_POWER       <= comp_on;
      if (comp_on & ~comp_prev_on_reg)
        start_cnt_reg <= STARTUP_CYC;
      else if (start_cnt_reg != 10'h000)
        start_cnt_reg <= start_cnt_reg - 10'h001;
    end
  end

  // sampling divider, restarted if a rate change leaves it past the end
  always @(posedge SYS_CLK)
  begin
    if (RESET)
      div_cnt_reg <= 6'h00;
    else if (tick | (div_cnt_reg >= scf_period(rate)))
      div_cnt_reg <= 6'h00;
    else
      div_cnt_reg <= div_cnt_reg + 6'h01;
  end

  // on-time delay counting
  always @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      drive_prev_reg <= 1'b0;
      dly_cnt_reg    <= 8'h00;
    end
    else
    begin
      drive_prev_reg <= PHASE_DRIVE_ON;
      if (drive_rise & ~ds_zero)
        dly_cnt_reg <= ds;
      else if (dly_cnt_reg != 8'h00)
        dly_cnt_reg <= dly_cnt_reg - 8'h01;
    end
  end

  // rate-paced sampling armed once the delay has run out
  always @(posedge SYS_CLK)
  begin
    if (RESET)
      scf_arm_reg <= 1'b0;
    else if ((drive_rise & ds_zero) | (dly_cnt_reg == 8'h01))
      scf_arm_reg <= 1'b1;
    else if (~PHASE_DRIVE_ON)
      scf_arm_reg <= 1'b0;
  end

  // input selection and its settling
  always @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      INPUT_SELECT   <= `BZCS_RST_SEL;
      sel_flag_reg   <= 4'h0;
      settle_cnt_reg <= 5'h00;
      ready_reg      <= 1'b0;
    end
    else
    begin
      if (wr_phase)
      begin
        INPUT_SELECT   <= REG_WDATA[`BZCS_PH_SEL_HI:`BZCS_PH_SEL_LO];
        sel_flag_reg   <= sel_onehot(REG_WDATA[`BZCS_PH_SEL_HI:`BZCS_PH_SEL_LO]);
        settle_cnt_reg <= SETTLE_CYC;
        ready_reg      <= 1'b0;
      end
      else
      begin
        if (settle_cnt_reg != 5'h00)
          settle_cnt_reg <= settle_cnt_reg - 5'h01;
        if (sel_smp)
          ready_reg <= 1'b1;
      end
    end
  end

  // free-running motor timer
  always @(posedge SYS_CLK)
  begin
    if (RESET)
      timer_reg <= 16'h0000;
    else
      timer_reg <= timer_reg + 16'h0001;
  end

  // sensor state follows the comparator at each sample point
  always @(posedge SYS_CLK)
  begin
    if (RESET)
      SENSOR_STATE <= 1'b0;
    else if (smp_any)
      SENSOR_STATE <= cmp_lvl;
  end

  // edge history and event pipelines
  always @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      cmp_prev_reg <= 1'b0;
      dm_last_reg  <= 1'b0;
      zc_pipe_reg  <= 2'h0;
      dm_pipe_reg  <= 2'h0;
      tc_pipe_reg  <= 3'h0;
    end
    else
    begin
      cmp_prev_reg <= cmp_lvl;
      if (active & tick)
        dm_last_reg <= cmp_lvl;
      zc_pipe_reg <= {zc_pipe_reg[0], zc_trig};
      dm_pipe_reg <= {dm_pipe_reg[0], dm_trig};
      tc_pipe_reg <= {tc_pipe_reg[1:0], tc_trig};
    end
  end

  // one-cycle event pulses at the end of each pipeline
  always @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      ZC_EVENT    <= 1'b0;
      DEMAG_EVENT <= 1'b0;
      TACHO_EVENT <= 1'b0;
    end
    else
    begin
      ZC_EVENT    <= zc_pipe_reg[1];
      DEMAG_EVENT <= dm_pipe_reg[1];
      TACHO_EVENT <= tc_pipe_reg[2];
    end
  end

  // captures take the timer on the edge that raises the event
  always @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      zc_cap_reg <= 16'h0000;
      dm_cap_reg <= 16'h0000;
      tc_cap_reg <= 16'h0000;
    end
    else
    begin
      if (zc_pipe_reg[1])
        zc_cap_reg <= timer_reg;
      if (dm_pipe_reg[1])
        dm_cap_reg <= timer_reg;
      if (tc_pipe_reg[2])
        tc_cap_reg <= timer_reg;
    end
  end

  // configuration write
  always @(posedge SYS_CLK)
  begin
    if (RESET)
      cfg_reg <= `BZCS_RST_CONFIG;
    else if (wr_cfg)
      cfg_reg <= REG_WDATA;
  end

  // read mux
  always @*
  begin
    rd_next = {DW{1'b0}};
    if (reg_hit(REG_ADDR, `BZCS_OFS_CONFIG))
      rd_next = cfg_reg;
    else if (reg_hit(REG_ADDR, `BZCS_OFS_PHASE))
    begin
      rd_next[`BZCS_PH_SEL_HI:`BZCS_PH_SEL_LO]   = INPUT_SELECT;
      rd_next[`BZCS_PH_FLAG_HI:`BZCS_PH_FLAG_LO] = sel_flag_reg;
      rd_next[`BZCS_PH_HST]                      = SENSOR_STATE;
      rd_next[`BZCS_PH_READY]                    = ready_reg;
      rd_next[`BZCS_PH_STARTUP]                  = comp_on & ~active;
    end
    else if (reg_hit(REG_ADDR, `BZCS_OFS_ZC_CAP))
      rd_next = zc_cap_reg;
    else if (reg_hit(REG_ADDR, `BZCS_OFS_DEMAG_CAP))
      rd_next = dm_cap_reg;
    else if (reg_hit(REG_ADDR, `BZCS_OFS_TACHO_CAP))
      rd_next = tc_cap_reg;
    else if (reg_hit(REG_ADDR, `BZCS_OFS_TIMER))
      rd_next = timer_reg;
    else
      rd_next = {DW{1'b0}};
  end

  // read data stands only in the cycle after the strobe
  always @(posedge SYS_CLK)
  begin
    if (RESET)
      REG_RDATA <= {DW{1'b0}};
    else if (REG_RD)
      REG_RDATA <= rd_next;
    else
      REG_RDATA <= {DW{1'b0}};
  end

endmodule

// ---- design/bzcs_defines.vh ----
// Purpose: constants of the zero-crossing sampler: offsets, fields, resets, timing
// Assumes: one timer cycle equals one SYS_CLK cycle
// Notes:   register offsets are word indices on the plain register port
`ifndef BZCS_DEFINES_VH
`define BZCS_DEFINES_VH

`define BZCS_ADDR_W          4
`define BZCS_DATA_W          16

`define BZCS_OFS_CONFIG      4'h0
`define BZCS_OFS_PHASE       4'h1
`define BZCS_OFS_ZC_CAP      4'h2
`define BZCS_OFS_DEMAG_CAP   4'h3
`define BZCS_OFS_TACHO_CAP   4'h4
`define BZCS_OFS_TIMER       4'h5

// motor_config_reg fields
`define BZCS_CFG_CKE         0
`define BZCS_CFG_REF         1
`define BZCS_CFG_MODE_LO     2
`define BZCS_CFG_MODE_HI     3
`define BZCS_CFG_TACHO       4
`define BZCS_CFG_DEMAG       5
`define BZCS_CFG_RATE_LO     6
`define BZCS_CFG_RATE_HI     7
`define BZCS_CFG_DLY_LO      8
`define BZCS_CFG_DLY_HI      15

// phase_state_reg fields
`define BZCS_PH_SEL_LO       0
`define BZCS_PH_SEL_HI       1
`define BZCS_PH_FLAG_LO      2
`define BZCS_PH_FLAG_HI      5
`define BZCS_PH_HST          6
`define BZCS_PH_READY        7
`define BZCS_PH_STARTUP      8

`define BZCS_RST_CONFIG      16'h0000
`define BZCS_RST_SEL         2'h0

// sampling modes
`define BZCS_MODE_OFF_END    2'h0
`define BZCS_MODE_CONT       2'h1
`define BZCS_MODE_ON_DLY     2'h2
`define BZCS_MODE_ON_DLY_SCF 2'h3

// timing
`define BZCS_CLK_PERIOD_NS   5
`define BZCS_STARTUP_NS      3000
`define BZCS_STARTUP_CYC     ((`BZCS_STARTUP_NS + `BZCS_CLK_PERIOD_NS - 1) / `BZCS_CLK_PERIOD_NS)
`define BZCS_SETTLE_NS       100
`define BZCS_SETTLE_CYC      ((`BZCS_SETTLE_NS + `BZCS_CLK_PERIOD_NS - 1) / `BZCS_CLK_PERIOD_NS)
`define BZCS_SCF_BASE_DIV    4
`define BZCS_TACHO_LAT       4
`define BZCS_CAPT_LAT        3

`endif

// ---- design/bzcs_sync.v ----
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: async_in is unrelated to clk
// Notes:   level_reg changes only when stages two and three agree
module bzcs_sync (
  input  wire clk,       // timer clock
  input  wire rst,       // synchronous reset, high
  input  wire async_in,  // asynchronous level
  output reg  level_reg  // filtered level
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_reg <= s3_reg;
    end
  end

endmodule

// ---- testbench/bzcs_checker_properties.sv ----
// Purpose: port-level timing checks of the zero-crossing sampler
// Assumes: one timer cycle per SYS_CLK; comparator change lands just after an edge
// Notes:   mode and delay tracked from config writes
module bzcs_checker #(
  parameter DW = 16,  // register data width
  parameter AW = 4    // register index width
) (
  input wire logic [AW-1:0] REG_ADDR,        // register index
  input wire logic [DW-1:0] REG_WDATA,       // write data
  input wire logic          SYS_CLK,         // timer clock
  input wire logic          RESET,           // synchronous reset
  input wire logic          REG_WR,          // write strobe
  input wire logic          REG_RD,          // read strobe
  input wire logic [DW-1:0] REG_RDATA,       // read data
  input wire logic          COMP_OUT,        // comparator output
  input wire logic          PHASE_DRIVE_ON,  // phase drive on
  input wire logic [1:0]    INPUT_SELECT,    // mux select
  input wire logic          COMP_POWER,      // comparator powered
  input wire logic          SENSOR_STATE,    // sensor state
  input wire logic          ZC_EVENT,        // zero-crossing pulse
  input wire logic          DEMAG_EVENT,     // demag pulse
  input wire logic          TACHO_EVENT      // tacho pulse
);
  logic [15:0] cfg_reg;
  logic [11:0] on_cnt_reg;
  logic [11:0] up_cnt_reg;
  logic        drv_d_reg;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // on_cnt_reg reads k in cycle k after the drive turns on
  always @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      cfg_reg    <= 16'h0000;
      on_cnt_reg <= 12'hfff;
      up_cnt_reg <= 12'h000;
      drv_d_reg  <= 1'b0;
    end
    else
    begin
      drv_d_reg  <= PHASE_DRIVE_ON;
      cfg_reg    <= (REG_WR && REG_ADDR == 4'h0) ? REG_WDATA[15:0] : cfg_reg;
      on_cnt_reg <= (PHASE_DRIVE_ON && !drv_d_reg) ? 12'h001 :
                    on_cnt_reg + {11'h000, on_cnt_reg != 12'hfff};
      up_cnt_reg <= !COMP_POWER ? 12'h000 : up_cnt_reg + {11'h000, up_cnt_reg != 12'hfff};
    end
  end
  property p_reset;
    $fell(RESET) |-> REG_RDATA == 0 && INPUT_SELECT == 2'h0 && !COMP_POWER && !SENSOR_STATE
      && !ZC_EVENT && !DEMAG_EVENT && !TACHO_EVENT;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  property p_rd_idle;
    !REG_RD |=> REG_RDATA == 0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_power;
    REG_WR && REG_ADDR == 4'h0
      |=> ##1 COMP_POWER == ($past(REG_WDATA[0], 2) | $past(REG_WDATA[1], 2));
  endproperty
  a_power: assert property (p_power) else $error("power does not follow enables");
  property p_select;
    REG_WR && REG_ADDR == 4'h1 |=> INPUT_SELECT == $past(REG_WDATA[1:0]);
  endproperty
  a_select: assert property (p_select) else $error("select not taken next cycle");
  property p_startup;
    up_cnt_reg < 12'd590 |-> !(ZC_EVENT || DEMAG_EVENT || TACHO_EVENT);
  endproperty
  a_startup: assert property (p_startup) else $error("event inside start-up filter");
  property p_zc_off;
    ZC_EVENT && (cfg_reg[3:2] == 2'h0 || cfg_reg[3:2] == 2'h2 && cfg_reg[15:8] == 8'h00)
      |-> on_cnt_reg == 12'd3;
  endproperty
  a_zc_off: assert property (p_zc_off) else $error("off-time capture not at cycle 3");
  property p_zc_dly;
    ZC_EVENT && cfg_reg[3:2] == 2'h2 && cfg_reg[15:8] != 8'h00
      |-> on_cnt_reg == {4'h0, cfg_reg[15:8]} + 12'd3;
  endproperty
  a_zc_dly: assert property (p_zc_dly) else $error("delayed capture not at delay+3");
  property p_tacho;
    TACHO_EVENT |-> $past(COMP_OUT, 8) != $past(COMP_OUT, 9);
  endproperty
  a_tacho: assert property (p_tacho) else $error("tacho capture not 4 after toggle");
  property p_demag;
    DEMAG_EVENT |=> !DEMAG_EVENT [*3];
  endproperty
  a_demag: assert property (p_demag) else $error("demag events closer than a tick");
endmodule
bind bzcs_sampler bzcs_checker #(.DW(DW), .AW(AW)) bzcs_checker_i (
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .SYS_CLK(SYS_CLK), .RESET(RESET),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .COMP_OUT(COMP_OUT),
  .PHASE_DRIVE_ON(PHASE_DRIVE_ON), .INPUT_SELECT(INPUT_SELECT), .COMP_POWER(COMP_POWER),
  .SENSOR_STATE(SENSOR_STATE), .ZC_EVENT(ZC_EVENT), .DEMAG_EVENT(DEMAG_EVENT),
  .TACHO_EVENT(TACHO_EVENT));

// ---- testbench/bzcs_partner.sv ----
// Purpose: comparator and phase drive seen by the sampler
// Assumes: bench sets the wanted levels right after a clock edge
// Notes:   comparator edge lands 2 ns later, off the clock edge
module bzcs_partner (
  input  wire logic comp_req,       // wanted comparator level
  input  wire logic drive_req,      // wanted phase drive state
  output logic      COMP_OUT,       // comparator output
  output wire logic PHASE_DRIVE_ON  // phase output on
);
  timeunit 1ns;
  timeprecision 100ps;
  initial COMP_OUT = 1'b0;
  always @(comp_req) COMP_OUT <= #2 comp_req;
  assign PHASE_DRIVE_ON = drive_req;
endmodule

// ---- testbench/tb.sv ----
// Purpose: self-checking bench of the zero-crossing sampler
// Assumes: cycle k counted at falling edges, k=0 the cycle of the change
// Notes:   start-up filter runs at full length
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        SYS_CLK = 1'b0;
  logic        RESET = 1'b1;
  logic [3:0]  REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic        comp_req = 1'b0;
  logic        drive_req = 1'b0;
  logic [15:0] rd_q;
  wire  [15:0] REG_RDATA;
  wire  [1:0]  INPUT_SELECT;
  wire         COMP_OUT, PHASE_DRIVE_ON, COMP_POWER, SENSOR_STATE;
  wire         ZC_EVENT, DEMAG_EVENT, TACHO_EVENT;
  int          n_errors = 0;
  int          n_compared = 0;
  int          tf [4];
  always #2.5 SYS_CLK = ~SYS_CLK;
  bzcs_partner bzcs_partner_i (.comp_req(comp_req), .drive_req(drive_req),
    .COMP_OUT(COMP_OUT), .PHASE_DRIVE_ON(PHASE_DRIVE_ON));
  bzcs_sampler bzcs_sampler_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .COMP_OUT(COMP_OUT), .PHASE_DRIVE_ON(PHASE_DRIVE_ON), .INPUT_SELECT(INPUT_SELECT),
    .COMP_POWER(COMP_POWER), .SENSOR_STATE(SENSOR_STATE), .ZC_EVENT(ZC_EVENT),
    .DEMAG_EVENT(DEMAG_EVENT), .TACHO_EVENT(TACHO_EVENT));
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(negedge SYS_CLK);
    rd_q = REG_RDATA;
  endtask
  // first cycle of zc, demag, tacho and sensor change
  task automatic obs(int lim);
    logic s0;
    s0 = SENSOR_STATE;
    tf = '{-1, -1, -1, -1};
    for (int k = 0; k < lim; k++)
    begin
      @(negedge SYS_CLK);
      if (ZC_EVENT === 1'b1 && tf[0] < 0) tf[0] = k;
      if (DEMAG_EVENT === 1'b1 && tf[1] < 0) tf[1] = k;
      if (TACHO_EVENT === 1'b1 && tf[2] < 0) tf[2] = k;
      if (SENSOR_STATE !== s0 && tf[3] < 0) tf[3] = k;
    end
  endtask
  task automatic rng(string nm, int i, int lo, int hi);
    if (tf[i] < 0)
    begin
      $display("BAD %s expected %0d seen none", nm, lo);
      n_errors++;
      close_out();
    end
    else
      chk(nm, 16'((tf[i] >= lo && tf[i] <= hi) ? lo : tf[i]), 16'(lo));
  endtask
  // comparator flips while drive is off, then one drive pulse
  task automatic pulse(logic [15:0] cfg);
    wr(4'h0, cfg);
    comp_req <= ~comp_req;
    idle(40);
    @(posedge SYS_CLK);
    drive_req <= 1'b1;
    obs(30);
    @(posedge SYS_CLK);
    drive_req <= 1'b0;
    idle(10);
  endtask
  task automatic t_regs();
    rd(4'h0);
    chk("config", rd_q, 16'h0000);
    rd(4'h1);
    chk("phase", 16'(rd_q[5:0]), 16'h0000);
    wr(4'h2, 16'h1234);
    rd(4'h2);
    chk("zc capture", rd_q, 16'h0000);
    rd(4'h6);
    chk("unmapped", rd_q, 16'h0000);
    $display("regs done");
  endtask
  task automatic t_startup();
    wr(4'h0, 16'h0003);
    rd(4'h1);
    chk("busy early", 16'(rd_q[8]), 16'h0001);
    idle(588);
    rd(4'h1);
    chk("busy late", 16'(rd_q[8]), 16'h0001);
    idle(12);
    rd(4'h1);
    chk("busy over", 16'(rd_q[8]), 16'h0000);
    $display("startup done");
  endtask
  task automatic t_sampling();
    pulse(16'h0003);
    rng("off sensor", 3, 1, 1);
    rng("off zc", 0, 3, 3);
    pulse(16'h050b);
    rng("dly sensor", 3, 6, 6);
    rng("dly zc", 0, 8, 8);
    pulse(16'h040f);
    rng("dly rate zc", 0, 8, 11);
    $display("sampling done");
  endtask
  task automatic t_tacho();
    logic [15:0] cap;
    wr(4'h0, 16'h0013);
    idle(40);
    @(posedge SYS_CLK);
    comp_req <= ~comp_req;
    obs(20);
    rng("tacho", 2, 8, 8);
    rd(4'h4);
    cap = rd_q;
    rd(4'h5);
    chk("tacho cap age", rd_q - cap, 16'h000f);
    $display("tacho done");
  endtask
  task automatic t_rate();
    for (int r = 0; r < 4; r++)
    begin
      wr(4'h0, 16'h0027 | 16'(r << 6));
      idle(80);
      @(posedge SYS_CLK);
      comp_req <= ~comp_req;
      obs(60);
      rng("rate zc", 0, 7, 7 + (4 << r));
      rng("rate demag", 1, 7, 7 + (4 << r));
    end
    $display("rate done");
  endtask
  task automatic t_select();
    wr(4'h0, 16'h0003);
    wr(4'h1, 16'h0002);
    rd(4'h1);
    chk("flag", 16'(rd_q[7:2]), 16'h0004);
    chk("mux", 16'(INPUT_SELECT), 16'h0002);
    idle(30);
    rd(4'h1);
    chk("ready", 16'(rd_q[7]), 16'h0001);
    $display("select done");
  endtask
  initial
  begin
    idle(10);
    RESET <= 1'b0;
    t_regs();
    t_startup();
    t_sampling();
    t_tacho();
    t_rate();
    t_select();
    close_out();
  end
endmodule
